// *** dv/mcd_chk_sva.sv ***
`default_nettype none
module mcd_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic move_done,
   input wire logic req_valid,
   input wire mcd_pkg::mcd_req_s req,
   input wire logic auxiliary_output
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---
   // Protocol and decode checks
   // ---
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel && penable;
   a_ready_high: assert property (pready) else $error("pready low");
   a_go_valid: assert property (acc && pwrite && paddr == 12'h018 && pwdata[0] |=> req_valid)
      else $error("no request after go");
   a_valid_pulse: assert property (req_valid |=> !req_valid) else $error("valid too long");
   a_req_hold: assert property (!req_valid |->
      $stable({req.refused, req.dir_neg, req.trig_en, req.target, req.load_val, req.seq}))
      else $error("request moved");
   a_aux_start: assert property (req_valid && !req.refused && req.aux_when == mcd_pkg::AUX_AT_START |->
      auxiliary_output == req.aux_level) else $error("auxiliary output not applied at start");
   a_seq_range: assert property (req_valid && !req.refused |-> req.seq <= 16'h7FFF)
      else $error("sequence out of range");
   a_load_kind: assert property (req_valid && !req.refused |->
      req.is_load == (req.instr inside {7'd14, 7'd21, 7'd62})) else $error("load kind wrong");
   a_bad_write: assert property (acc && pwrite && paddr > 12'h038 |-> pslverr)
      else $error("unmapped write accepted");
   a_bad_read: assert property (acc && !pwrite && paddr > 12'h038 |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_idle_zero: assert property (!acc |-> prdata == 32'h0) else $error("read data outside access");
endmodule : mcd_chk
bind mcd_decoder mcd_chk mcd_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .move_done(move_done), .req_valid(req_valid), .req(req), .auxiliary_output(auxiliary_output));
`default_nettype wire

// *** dv/mcd_engine.sv ***
`default_nettype none
module mcd_engine #(parameter int DELAY = 20) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req_valid,
   output logic move_done
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   // A new request restarts the count, so only the last movement ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         move_done <= 1'b0;
      end else begin
         move_done <= (cnt == 1);
         if (req_valid) begin
            cnt <= DELAY;
         end else if (cnt != 0) begin
            cnt <= cnt - 1;
         end
      end
   end
endmodule : mcd_engine
`default_nettype wire

// *** dv/motion_command_decoder_bench.sv ***
`default_nettype none
module motion_command_decoder_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, move_done, req_valid, auxiliary_output, err;
   mcd_pkg::mcd_req_s req;
   logic [6:0] codes [12] = '{9, 1, 32, 30, 10, 11, 5, 7, 14, 62, 21, 4};
   logic [6:0] bad [4][2] = '{'{90, 2}, '{60, 9}, '{68, 9}, '{93, 9}};
   int miscompares = 0;
   int checked = 0;
   always #5 pclk = ~pclk;
   mcd_decoder mcd_decoder_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .move_done(move_done), .req_valid(req_valid), .req(req), .auxiliary_output(auxiliary_output));
   mcd_engine #(.DELAY(20)) mcd_engine_inst (.pclk(pclk), .presetn(presetn), .req_valid(req_valid),
      .move_done(move_done));
   // ---
   // Tasks
   // ---
   task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s exp %0h seen %0h", n, e, s);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // pready is tied high in the decoder, so this wait ends on its first edge
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : bus
   task automatic go(input logic [15:0] s, input logic [6:0] m, g, input logic [31:0] x, f,
                     input logic [15:0] aux, input logic [31:0] p, input logic inf);
      bus(1, 12'h000, {16'h0, s});
      bus(1, 12'h004, {25'h0, m});
      bus(1, 12'h008, {25'h0, g});
      bus(1, 12'h00C, x);
      bus(1, 12'h010, f);
      bus(1, 12'h014, {16'h0, aux});
      bus(1, 12'h020, p);
      bus(1, 12'h018, {30'h0, inf, 1'b1});
      @(posedge pclk);
      chk("req_valid", req_valid, 1'b1);
      @(posedge pclk);
   endtask : go
   task automatic tgt(input logic [31:0] t, input logic d);
      chk("target", req.target, t);
      chk("dir_neg", req.dir_neg, d);
   endtask : tgt
   task automatic final_report();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report
   // ---
   // Tests
   // ---
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      bus(0, 12'h01C, 0);
      chk("modulo", rd, 32'h0000EA60);
      go(1, 90, 9, 5000, 7, 16'h0101, 1000, 0);
      tgt(5000, 0);
      chk("speed", req.speed_scaled, 7000);
      chk("aux_mode", {req.aux_when, req.aux_level}, 3);
      chk("aux_out", auxiliary_output, 1);
      go(2, 91, 1, -400, 1, 0, 1000, 0);
      tgt(600, 1);
      foreach (codes[k]) begin
         go(k, 90, codes[k], 300, 1, 16'h3000, 0, 0);
         chk("refused", req.refused, 0);
         chk("is_load", req.is_load, codes[k] inside {14, 21, 62});
         if (codes[k] inside {14, 21, 62}) begin
            tgt(0, 0);
            chk("load_val", req.load_val, 300);
         end
         chk("trig", req.trig_en, codes[k] inside {10, 11, 5, 7});
         chk("wait_mod", req.wait_mod, codes[k] == 5);
      end
      foreach (bad[k]) begin
         go(20, bad[k][0], bad[k][1], 0, 1, 0, 0, 0);
         chk("refused", req.refused, 1);
      end
      go(16'h8000, 90, 9, 0, 1, 0, 0, 0);
      chk("seq_refused", req.refused, 1);
      bus(1, 12'h100, 5);
      chk("wr_err", err, 1);
      bus(0, 12'h100, 0);
      chk("rd_zero", rd, 0);
      go(3, 90, 7, 0, 1, 0, 40000, 0);
      go(4, 68, 9, 45000, -1000, 0, 0, 1);
      tgt(25000, 1);
      go(5, 68, 9, 45000, 1000, 0, 0, 1);
      tgt(25000, 0);
      go(6, 98, 9, 45000, 1, 0, 30000, 1);
      tgt(25000, 1);
      go(7, 91, 9, -15000, 1, 0, 10000, 1);
      tgt(55000, 1);
      go(8, 60, 9, 100, -5, 0, 0, 1);
      chk("dir_neg", req.dir_neg, 1);
      go(9, 90, 9, 50000, 1, 0, 10000, 1);
      chk("dir_neg", req.dir_neg, 1);
      bus(0, 12'h02C, 0);
      chk("ref", rd, 40000);
      go(11, 90, 10, 0, 1, 16'h0300, 0, 0);
      chk("trig_off", req.trig_en, 0);
      chk("aux_keep", auxiliary_output, 1);
      go(10, 90, 9, 10, 1, 16'h0200, 0, 0);
      chk("aux_hold", auxiliary_output, 1);
      for (int i = 0; i < 40 && move_done !== 1'b1; i++) @(posedge pclk);
      repeat (2) @(posedge pclk);
      chk("aux_end", auxiliary_output, 0);
      final_report();
   end
   initial begin
      repeat (5000) @(posedge pclk);
      miscompares++;
      final_report();
   end
endmodule : motion_command_decoder_bench
`default_nettype wire

// *** src/mcd_cfg.svh ***
`ifndef MCD_CFG_SVH
`define MCD_CFG_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define MCD_OFF_SEQ 12'h000
`define MCD_OFF_MTYPE 12'h004
`define MCD_OFF_INSTR 12'h008
`define MCD_OFF_COORD 12'h00C
`define MCD_OFF_SPEED 12'h010
`define MCD_OFF_AUX 12'h014
`define MCD_OFF_CTRL 12'h018
`define MCD_OFF_MODULO 12'h01C
`define MCD_OFF_POS 12'h020
`define MCD_OFF_STATUS 12'h024
`define MCD_OFF_TARGET 12'h028
`define MCD_OFF_REF 12'h02C
`define MCD_OFF_LOADVAL 12'h030
`define MCD_OFF_SPDOUT 12'h034
`define MCD_OFF_DONE 12'h038
// ----------------------------------------
// Field positions and limits
// ----------------------------------------
`define MCD_SEQ_MAX 16'h7FFF
`define MCD_BIT_TRIG 12
`define MCD_BIT_WAITMOD 13
`define MCD_SPEED_SCALE 32'h0000_03E8
`define MCD_CTRL_GO 0
`define MCD_CTRL_INF 1
`define MCD_CTRL_AUXEND 0
`define MCD_MODULO_RST 32'h0000_EA60
`endif

// *** src/mcd_decoder.sv ***
// Implementation choices: the APB register port and the register addresses.
`include "mcd_cfg.svh"
`default_nettype none
//
// Overview of operation
// - Sequence number ranges 0 to 32767 and is reported with the request.
// - Type 90 absolute, 91 relative to position, 98 relative to stored reference.
// - Type 60 absolute with imposed direction, infinite machine only.
// - Type 68 reference-relative with imposed direction, infinite machine only.
// - Stored reference captured only when store-position instruction executes.
// - Reference instructions 14, 21, 62 use coordinate as value to load.
// - Speed field is in thousand length units per minute.
// - Control bit 12 enables event trigger for 10, 11, 05, 07.
// - Nibble 2: 0 unchanged, 1 apply at start, 2 apply at end.
// - Nibble 0 gives auxiliary level for moves 01, 09, 10, 11; the code takes bit 0 as the level for any accepted instruction.
// - For wait-event, bit 13 selects timeout/event or modulo-crossing count.
// - Accept codes 09, 01, 32, 30.
// - Accept codes 10, 11, 05, 07.
// - Accept codes 14, 62, 21, 04.
// - Infinite machine type 90 takes the shorter path direction.
// - Infinite machine type 60 direction follows speed sign.
// - Infinite machine type 91 direction follows coordinate sign.
// - Infinite type 98 targets coordinate plus reference, shorter path.
// - Infinite type 68 targets coordinate plus reference, direction by speed sign.
// - Infinite targets for 68 and 91 reduced modulo configured value.
module mcd_decoder (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic move_done,
   output logic req_valid,
   output mcd_pkg::mcd_req_s req,
   output logic auxiliary_output
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic instr_ok(input logic [6:0] c);
      unique case (c)
         mcd_pkg::IC_POS_STOP, mcd_pkg::IC_POS_FLY, mcd_pkg::IC_MACH_PREP, mcd_pkg::IC_MACH: instr_ok = 1'b1;
         mcd_pkg::IC_EVT_STOP, mcd_pkg::IC_EVT_FLY, mcd_pkg::IC_WAIT_EVT, mcd_pkg::IC_STORE_POS:
            instr_ok = 1'b1;
         mcd_pkg::IC_REF_PT, mcd_pkg::IC_REF_FORCED, mcd_pkg::IC_REF_FLY, mcd_pkg::IC_STOP:
            instr_ok = 1'b1;
         default: instr_ok = 1'b0;
      endcase
   endfunction : instr_ok

   // Modulo reduction of a signed value into [0, m); zero modulo leaves it alone
   function automatic logic signed [31:0] wrap(input logic signed [31:0] v, input logic [31:0] m);
      logic signed [32:0] r;
      r = 33'sd0;
      if (m == 32'h0) begin
         wrap = v;
      end else begin
         r = 33'(v) % $signed({1'b0, m});
         if (r < 0) begin
            r = r + $signed({1'b0, m});
         end
         wrap = r[31:0];
      end
   endfunction : wrap

   mcd_pkg::mcd_state_s s_q, s_d;

   logic acc;
   logic wr;
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign pready = 1'b1;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic mt_ok;
      logic inf_only;
      logic signed [31:0] tgt;
      logic signed [31:0] diff;
      logic [31:0] half;
      logic neg;
      mt_ok = 1'b0;
      inf_only = 1'b0;
      tgt = 32'sh0;
      diff = 32'sh0;
      half = 32'h0;
      neg = 1'b0;
      s_d = s_q;
      s_d.req.valid = 1'b0;
      pslverr = 1'b0;

      if (wr) begin
         unique case (paddr)
            `MCD_OFF_SEQ: begin
               s_d.cmd.seq = pwdata[15:0];
               pslverr = (pwdata[15:0] > `MCD_SEQ_MAX);
            end
            `MCD_OFF_MTYPE: s_d.cmd.mtype = pwdata[6:0];
            `MCD_OFF_INSTR: s_d.cmd.instr = pwdata[6:0];
            `MCD_OFF_COORD: s_d.cmd.coord = pwdata;
            `MCD_OFF_SPEED: s_d.cmd.speed = pwdata;
            `MCD_OFF_AUX: s_d.cmd.aux = pwdata[15:0];
            `MCD_OFF_CTRL: s_d.inf = pwdata[`MCD_CTRL_INF];
            `MCD_OFF_MODULO: s_d.modulo = pwdata;
            `MCD_OFF_POS: s_d.pos = pwdata;
            `MCD_OFF_STATUS, `MCD_OFF_TARGET, `MCD_OFF_REF, `MCD_OFF_LOADVAL, `MCD_OFF_SPDOUT,
            `MCD_OFF_DONE: ;
            default: pslverr = 1'b1;
         endcase
      end

      // Decode on a write to CTRL with the go bit set
      if (wr && paddr == `MCD_OFF_CTRL && pwdata[`MCD_CTRL_GO]) begin
         unique case (s_q.cmd.mtype)
            mcd_pkg::MT_ABS, mcd_pkg::MT_REL, mcd_pkg::MT_REF: mt_ok = 1'b1;
            mcd_pkg::MT_ABS_DIR, mcd_pkg::MT_REF_DIR: begin
               mt_ok = 1'b1;
               inf_only = 1'b1;
            end
            default: mt_ok = 1'b0;
         endcase
         s_d.req.seq = s_q.cmd.seq;
         s_d.req.instr = s_q.cmd.instr;
         s_d.req.valid = 1'b1;
         // Refusal also covers an out-of-range sequence number
         s_d.req.refused = !mt_ok || !instr_ok(s_q.cmd.instr) || (inf_only && !pwdata[`MCD_CTRL_INF]) ||
                           (s_q.cmd.seq > `MCD_SEQ_MAX);
         s_d.req.speed_scaled = 48'(s_q.cmd.speed) * $signed({16'h0, `MCD_SPEED_SCALE});
         s_d.req.trig_en = s_q.cmd.aux[`MCD_BIT_TRIG] && (s_q.cmd.instr == mcd_pkg::IC_EVT_STOP ||
                           s_q.cmd.instr == mcd_pkg::IC_EVT_FLY || s_q.cmd.instr == mcd_pkg::IC_WAIT_EVT ||
                           s_q.cmd.instr == mcd_pkg::IC_STORE_POS);
         s_d.req.wait_mod = s_q.cmd.aux[`MCD_BIT_WAITMOD] && s_q.cmd.instr == mcd_pkg::IC_WAIT_EVT;
         // Any nibble value outside 0 to 2 is held as AUX_BAD, which changes nothing, so the upper bits may not alias
         s_d.req.aux_when = (s_q.cmd.aux[11:10] != 2'b00) ? mcd_pkg::AUX_BAD :
                            mcd_pkg::mcd_auxwhen_e'(s_q.cmd.aux[9:8]);
         s_d.req.aux_level = s_q.cmd.aux[0];
         s_d.req.is_load = (s_q.cmd.instr == mcd_pkg::IC_REF_PT || s_q.cmd.instr == mcd_pkg::IC_REF_FLY ||
                            s_q.cmd.instr == mcd_pkg::IC_REF_FORCED);
         s_d.req.load_val = s_d.req.is_load ? s_q.cmd.coord : 32'sh0;

         unique case (s_q.cmd.mtype)
            mcd_pkg::MT_REL: tgt = s_q.pos + s_q.cmd.coord;
            mcd_pkg::MT_REF, mcd_pkg::MT_REF_DIR: tgt = s_q.cmd.coord + s_q.ref_pos;
            default: tgt = s_q.cmd.coord;
         endcase
         neg = (tgt < s_q.pos);
         if (pwdata[`MCD_CTRL_INF]) begin
            if (s_q.cmd.mtype == mcd_pkg::MT_REL || s_q.cmd.mtype == mcd_pkg::MT_REF_DIR) begin
               tgt = wrap(tgt, s_q.modulo);
            end else if (s_q.cmd.mtype == mcd_pkg::MT_ABS || s_q.cmd.mtype == mcd_pkg::MT_REF) begin
               tgt = wrap(tgt, s_q.modulo);
            end
            unique case (s_q.cmd.mtype)
               mcd_pkg::MT_ABS, mcd_pkg::MT_REF: begin
                  // Shorter path: forward distance mod M against half of M
                  diff = wrap(tgt - wrap(s_q.pos, s_q.modulo), s_q.modulo);
                  half = s_q.modulo >> 1;
                  neg = ($unsigned(diff) > half);
               end
               mcd_pkg::MT_ABS_DIR, mcd_pkg::MT_REF_DIR: neg = s_q.cmd.speed[31];
               mcd_pkg::MT_REL: neg = s_q.cmd.coord[31];
               default: neg = 1'b0;
            endcase
         end
         s_d.req.target = s_d.req.is_load ? s_q.pos : tgt;
         s_d.req.dir_neg = neg;
         // Stored reference only moves on an accepted store-position command
         if (!s_d.req.refused && s_q.cmd.instr == mcd_pkg::IC_STORE_POS) begin
            s_d.ref_pos = s_q.pos;
         end
         if (!s_d.req.refused && s_d.req.aux_when == mcd_pkg::AUX_AT_START) begin
            s_d.aux_out = s_q.cmd.aux[0];
         end
      end

      // Deferred auxiliary level applied when the movement reports its end
      if (move_done && !s_q.req.refused && s_q.req.aux_when == mcd_pkg::AUX_AT_END) begin
         s_d.aux_out = s_q.req.aux_level;
      end

      unique case (paddr)
         `MCD_OFF_SEQ: s_d.prdata = {16'h0, s_q.cmd.seq};
         `MCD_OFF_MTYPE: s_d.prdata = {25'h0, s_q.cmd.mtype};
         `MCD_OFF_INSTR: s_d.prdata = {25'h0, s_q.cmd.instr};
         `MCD_OFF_COORD: s_d.prdata = s_q.cmd.coord;
         `MCD_OFF_SPEED: s_d.prdata = s_q.cmd.speed;
         `MCD_OFF_AUX: s_d.prdata = {16'h0, s_q.cmd.aux};
         `MCD_OFF_CTRL: s_d.prdata = {30'h0, s_q.inf, 1'b0};
         `MCD_OFF_MODULO: s_d.prdata = s_q.modulo;
         `MCD_OFF_POS: s_d.prdata = s_q.pos;
         `MCD_OFF_STATUS: s_d.prdata = {24'h0, s_q.aux_out, s_q.req.aux_when, s_q.req.aux_level,
                                        s_q.req.wait_mod, s_q.req.trig_en, s_q.req.dir_neg, s_q.req.refused};
         `MCD_OFF_TARGET: s_d.prdata = s_q.req.target;
         `MCD_OFF_REF: s_d.prdata = s_q.ref_pos;
         `MCD_OFF_LOADVAL: s_d.prdata = s_q.req.load_val;
         `MCD_OFF_SPDOUT: s_d.prdata = s_q.req.speed_scaled[31:0];
         `MCD_OFF_DONE: s_d.prdata = {16'h0, s_q.req.seq};
         default: s_d.prdata = 32'h0;
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
         s_q.modulo <= `MCD_MODULO_RST;
         s_q.cmd.mtype <= 7'd90;
         s_q.cmd.instr <= 7'd9;
      end else begin
         s_q <= s_d;
      end
   end

   // Read data is combinational from state so it is valid in the access phase
   always_comb begin
      prdata = 32'h0;
      if (acc && !pwrite) begin
         prdata = s_d.prdata;
      end
   end

   assign req_valid = s_q.req.valid;
   assign req = s_q.req;
   assign auxiliary_output = s_q.aux_out;

endmodule : mcd_decoder
`default_nettype wire

// *** src/mcd_pkg.sv ***
`default_nettype none
package mcd_pkg;
   typedef enum logic [6:0] {
      MT_ABS = 7'd90, MT_REL = 7'd91, MT_REF = 7'd98, MT_ABS_DIR = 7'd60, MT_REF_DIR = 7'd68
   } mcd_mtype_e;
   typedef enum logic [6:0] {
      IC_POS_STOP = 7'd9, IC_POS_FLY = 7'd1, IC_MACH_PREP = 7'd32, IC_MACH = 7'd30,
      IC_EVT_STOP = 7'd10, IC_EVT_FLY = 7'd11, IC_WAIT_EVT = 7'd5, IC_STORE_POS = 7'd7,
      IC_REF_PT = 7'd14, IC_REF_FORCED = 7'd62, IC_REF_FLY = 7'd21, IC_STOP = 7'd4
   } mcd_instr_e;
   typedef enum logic [1:0] {AUX_NONE, AUX_AT_START, AUX_AT_END, AUX_BAD} mcd_auxwhen_e;
   typedef struct packed {
      logic [15:0] seq;
      logic [6:0] mtype;
      logic [6:0] instr;
      logic signed [31:0] coord;
      logic signed [31:0] speed;
      logic [15:0] aux;
   } mcd_cmd_s;
   typedef struct packed {
      logic valid;
      logic refused;
      logic dir_neg;
      logic is_load;
      logic trig_en;
      logic wait_mod;
      logic aux_level;
      mcd_auxwhen_e aux_when;
      logic signed [31:0] target;
      logic signed [31:0] load_val;
      logic signed [47:0] speed_scaled;
      logic [15:0] seq;
      logic [6:0] instr;
   } mcd_req_s;
   typedef struct packed {
      mcd_cmd_s cmd;
      logic inf;
      logic [31:0] modulo;
      logic signed [31:0] pos;
      logic signed [31:0] ref_pos;
      mcd_req_s req;
      logic aux_out;
      logic [31:0] prdata;
   } mcd_state_s;
endpackage : mcd_pkg
`default_nettype wire
